// [bench/pbsp_host.sv]
// Host controller model: drives one command per clock and pipelines data
`timescale 1ns/1ps
`default_nettype none

module pbsp_host
  import pbsp_pkg::*;
(
  input  wire logic        clk_i,
  output var  logic        qual_n_o,
  output var  logic        adv_o,
  output var  logic        we_n_o,
  output var  logic        sleep_o,
  output var  logic        oe_n_o,
  output var  logic [2:0]  sel_o,
  output var  logic [3:0]  lane_n_o,
  output var  logic [18:0] addr_o,
  output var  logic [35:0] wd_o
);
  logic [35:0] d1;
  logic [35:0] d2;

  initial begin
    {qual_n_o, adv_o, we_n_o, sleep_o, oe_n_o} = 5'h04;
    {sel_o, lane_n_o, addr_o, wd_o} = {3'h5, 4'hf, 19'h0, 36'h0};
    d1 = 36'h0;
    d2 = 36'h0;
  end

  // Data rides two qualified edges behind its command; stalls hold the pipeline but invert wd_o
  task automatic step(input logic q, a, w, z, o, input logic [2:0] s,
                      input logic [3:0] ln, input logic [18:0] ad,
                      input logic [35:0] d);
    @(posedge clk_i);
    {qual_n_o, adv_o, we_n_o, sleep_o, oe_n_o} <= {q, a, w, z, o};
    {sel_o, lane_n_o, addr_o} <= {s, ln, ad};
    if (!q) begin
      wd_o <= d2;
      d2 = d1;
      d1 = d;
    end else begin
      wd_o <= ~wd_o;
    end
  endtask
endmodule

`default_nettype wire

// [bench/tb_pbsp_top.sv]
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ps
`default_nettype none

module tb_pbsp_top
  import pbsp_pkg::*;
;
  localparam logic [2:0] ACT = 3'h2;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap = 1'b0;
  logic        sleep = 1'b0;
  logic        oe_n = 1'b0;
  logic        qseen = 1'b0;
  logic        hq, ha, hw, hz, ho, doe, poe;
  logic [2:0]  hs;
  logic [3:0]  hl, pq;
  logic [18:0] hadr, base;
  logic [35:0] hd;
  logic [31:0] dq;
  logic [1:0]  cnt;
  logic        bdir, bact;
  logic [31:0] lfsr = 32'h3a6994d1;
  logic [35:0] mem [logic [18:0]];
  logic [35:0] expq [$];
  int          num_errors = 0;
  int          compares = 0;
  int          cyc = 0;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  pbsp_host pbsp_host_i (.clk_i(clk), .qual_n_o(hq), .adv_o(ha),
    .we_n_o(hw), .sleep_o(hz), .oe_n_o(ho), .sel_o(hs), .lane_n_o(hl),
    .addr_o(hadr), .wd_o(hd));

  pbsp_top pbsp_top_i (.CLK_SYS_I(clk), .SYS_RST_I(rst),
    .CLOCK_QUALIFIER_N_I(hq), .CHIP_SELECT_FIRST_N_I(hs[0]),
    .CHIP_SELECT_SECOND_I(hs[1]), .CHIP_SELECT_THIRD_N_I(hs[2]),
    .ADVANCE_OR_LOAD_I(ha), .WRITE_STROBE_N_I(hw),
    .BYTE_LANE_WRITE_SELECT_N_I(hl), .ADDR_I(hadr),
    .OUTPUT_DRIVE_ENABLE_N_I(ho), .BURST_ORDER_I(strap),
    .SLEEP_REQUEST_I(hz), .DATA_I(hd[31:0]), .DATA_O(dq),
    .DATA_OE_O(doe), .BYTE_PARITY_LINES_I(hd[35:32]),
    .BYTE_PARITY_LINES_O(pq), .BYTE_PARITY_LINES_OE_O(poe));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk_data(input logic [35:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_drive(input logic got, exp, input string m);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %b exp %b", $time, m, got, exp);
    end
  endtask

  function automatic logic [35:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return {lfsr[7:4], lfsr};
  endfunction

  // Drives one command and notes what the port must answer
  task automatic op(input logic q, a, w, input logic [2:0] s,
                    input logic [3:0] ln, input logic [18:0] ad);
    logic [35:0] d;
    logic [18:0] x;
    d = rnd();
    pbsp_host_i.step(q, a, w, sleep, oe_n, s, ln, ad, d);
    if (!q && !a) begin
      base = ad;
      cnt = 2'h0;
      bdir = ~w;
      bact = (s == ACT) && !sleep;
    end else if (!q) begin
      cnt = cnt + 2'h1;
    end
    x = {base[18:2], strap ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (!q && bact && bdir) begin
      if (!mem.exists(x)) mem[x] = 36'h0;
      for (int l = 0; l < 4; l++) begin
        if (!ln[l]) mem[x][l*8+:8] = d[l*8+:8];
        if (!ln[l]) mem[x][32+l] = d[32+l];
      end
    end else if (!q && bact && !oe_n) begin
      expq.push_back(mem[x]);
    end
  endtask

  // Advances swap strobe and drop selects: both must be ignored
  task automatic burst(input logic w, input logic [18:0] a, input int n);
    op(1'b0, 1'b0, w, ACT, 4'h0, a);
    repeat (n - 1) op(1'b0, 1'b1, ~w, 3'h0, {4{w}}, a);
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 1'b1, 3'h5, 4'hf, 19'h0);
  endtask

  // ---------------------------------------------------------------------
  // Monitor and timeout
  // ---------------------------------------------------------------------
  always @(posedge clk) begin
    qseen <= ~hq;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      test_done();
    end
  end

  // An unknown enable would slip past the data checks, so it is caught here
  always @(negedge clk) begin
    chk_drive(poe, doe, "parity enable");
    if (qseen && doe !== 1'b0 && doe !== 1'b1)
      chk_drive(doe, 1'b0, "drive unknown");
    else if (qseen && doe && expq.size() == 0)
      chk_drive(doe, 1'b0, "unexpected drive");
    else if (qseen && doe)
      chk_data({pq, dq}, expq.pop_front(), "read data");
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    logic [35:0] r;
    logic [18:0] a;
    logic [18:0] b;
    logic [2:0]  desel [3];
    desel = '{3'h3, 3'h0, 3'h6};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    r = rnd();
    a = {r[18:2], 2'h3};
    b = a ^ 19'h40;
    burst(1'b0, a, 4);
    burst(1'b1, a, 5);
    idle(3);
    $display("linear burst test done");
    for (int m = 0; m < 16; m++) begin
      op(1'b0, 1'b0, 1'b0, ACT, 4'(m), b);
      op(1'b0, 1'b0, 1'b1, ACT, 4'h0, b);
    end
    for (int k = 0; k < 3; k++) begin
      op(1'b0, 1'b0, 1'b1, desel[k], 4'h0, a);
      op(1'b0, 1'b1, 1'b1, ACT, 4'h0, a);
      op(1'b0, 1'b0, 1'b1, ACT, 4'h0, b);
    end
    idle(3);
    $display("lane and select test done");
    op(1'b0, 1'b0, 1'b0, ACT, 4'h6, b);
    repeat (2) op(1'b1, 1'b0, 1'b0, ACT, 4'h0, r[18:0]);
    op(1'b0, 1'b0, 1'b1, ACT, 4'h0, a);
    repeat (2) op(1'b1, 1'b1, 1'b0, ACT, 4'h0, r[18:0]);
    repeat (2) op(1'b0, 1'b1, 1'b1, ACT, 4'h0, a);
    op(1'b0, 1'b0, 1'b1, ACT, 4'h0, b);
    idle(3);
    oe_n = 1'b1;
    burst(1'b1, a, 2);
    idle(3);
    oe_n = 1'b0;
    $display("stall and enable test done");
    @(posedge clk);
    rst <= 1'b1;
    strap <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    burst(1'b1, a ^ 19'h2, 4);
    idle(3);
    $display("interleaved test done");
    sleep = 1'b1;
    idle(6);
    sleep = 1'b0;
    idle(3);
    burst(1'b1, a, 4);
    idle(3);
    chk_data(36'(expq.size()), 36'h0, "reads left");
    $display("sleep test done");
    test_done();
  end
endmodule

`default_nettype wire

// [src/pbsp_mem.sv]
// Storage array with byte-lane writes and registered read data
`timescale 1ns/1ps
`default_nettype none

module pbsp_mem
  import pbsp_pkg::*;
#(
  parameter int ADDR_W = PBSP_ADDR_W_DEF,
  parameter int LANES  = PBSP_LANES_DEF,
  parameter int LANE_W = PBSP_LANE_W_DEF + PBSP_PARITY_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      rd_en_i,
  input  wire logic [ADDR_W-1:0]         rd_addr_i,
  output var  logic [LANES*LANE_W-1:0]   rd_data_o,
  input  wire logic                      wr_en_i,
  input  wire logic [ADDR_W-1:0]         wr_addr_i,
  input  wire logic [LANES-1:0]          wr_lane_i,
  input  wire logic [LANES*LANE_W-1:0]   wr_data_i
);

  logic [LANES*LANE_W-1:0] mem_q [2**ADDR_W];
  logic [LANES*LANE_W-1:0] rd_q;

  // ---------------------------------------------------------------------
  // Write-first per lane, so a read issued on the write's completing edge
  // sees the fresh bytes instead of stale array contents
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_en_i && wr_lane_i[l]) begin
        mem_q[wr_addr_i][l*LANE_W +: LANE_W] <= wr_data_i[l*LANE_W +: LANE_W];
      end
      if (rd_en_i) begin
        if (wr_en_i && wr_lane_i[l] && (wr_addr_i == rd_addr_i)) begin
          rd_q[l*LANE_W +: LANE_W] <= wr_data_i[l*LANE_W +: LANE_W];
        end else begin
          rd_q[l*LANE_W +: LANE_W] <= mem_q[rd_addr_i][l*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign rd_data_o = rd_q;

endmodule

`default_nettype wire

// [src/pbsp_pkg.sv]
// Shared constants and carrier types for the pipelined burst SRAM port
package pbsp_pkg;

  // ---------------------------------------------------------------------
  // Geometry defaults
  // ---------------------------------------------------------------------
  localparam int PBSP_ADDR_W_DEF   = 19;
  localparam int PBSP_LANES_DEF    = 4;
  localparam int PBSP_LANE_W_DEF   = 8;
  localparam int PBSP_PARITY_W     = 1;
  localparam int PBSP_MIN_ADDR_W   = 3;

  // ---------------------------------------------------------------------
  // Burst counter
  // ---------------------------------------------------------------------
  localparam int          PBSP_BURST_W     = 2;
  localparam logic [1:0]  PBSP_BURST_START = 2'h0;
  localparam logic [1:0]  PBSP_BURST_STEP  = 2'h1;

  // ---------------------------------------------------------------------
  // Sleep timing and reset values
  // ---------------------------------------------------------------------
  localparam int   PBSP_SLEEP_CYCLES = 2;
  localparam logic PBSP_RST_DRIVE    = 1'b0;
  localparam logic PBSP_RST_SLEEP    = 1'b0;

  // Burst order strap: low is linear, high is interleaved
  typedef enum logic {
    PBSP_LINEAR,
    PBSP_INTERLEAVED
  } pbsp_order_e;

  // Decoded command seen at one clock edge
  typedef struct packed {
    logic qual;
    logic sel;
    logic adv;
    logic write;
  } pbsp_cmd_s;

endpackage

// [src/pbsp_top.sv]
// Pipelined burst SRAM port: command pipeline, burst counter, output stage
//
// Functional notes
// - Clock qualifier high while awake: edge ignored, all state but the sleep synchroniser held.
// - Qualified load, all selects active, strobe high starts a read.
// - Read data leaves through output register one edge later, gated by enable.
// - After the read edge the drivers follow output enable and control.
// - A new command is accepted in the cycle right after a read.
// - Deselect is pipelined; outputs float after the following edge.
// - Burst counter touches only the two lowest address bits, wrapping in four.
// - Strap low gives linear order, high gives interleaved order.
// - Interleaved: burst address is start XOR step count.
// - Linear: burst address is previous plus one modulo four.
// - Advance high increments the counter whatever selects and strobe say.
// - Direction captured at load and kept through the burst.
// - Qualified load with selects active and strobe low starts a write.
// - Edge after a write command floats data and parity lines.
// - Write data taken two edges after the command and stored.
// - Only lanes with their select low are written, parity included.
// - Burst write continuation ignores selects and strobe, advances counter.
// - Sleep request takes two cycles to enter and to leave; data kept.
// - Operations pending at sleep entry are dropped.
// - Starts deselected with lines floating regardless of output enable.
// - First clock after leaving deselect keeps outputs floating.
`timescale 1ns/1ps
`default_nettype none

module pbsp_top
  import pbsp_pkg::*;
#(
  parameter int ADDR_W = PBSP_ADDR_W_DEF,
  parameter int LANES  = PBSP_LANES_DEF,
  parameter int LANE_W = PBSP_LANE_W_DEF
) (
  input  wire logic                    CLK_SYS_I,
  input  wire logic                    SYS_RST_I,
  input  wire logic                    CLOCK_QUALIFIER_N_I,
  input  wire logic                    CHIP_SELECT_FIRST_N_I,
  input  wire logic                    CHIP_SELECT_SECOND_I,
  input  wire logic                    CHIP_SELECT_THIRD_N_I,
  input  wire logic                    ADVANCE_OR_LOAD_I,
  input  wire logic                    WRITE_STROBE_N_I,
  input  wire logic [LANES-1:0]        BYTE_LANE_WRITE_SELECT_N_I,
  input  wire logic [ADDR_W-1:0]       ADDR_I,
  input  wire logic                    OUTPUT_DRIVE_ENABLE_N_I,
  input  wire logic                    BURST_ORDER_I,
  input  wire logic                    SLEEP_REQUEST_I,
  input  wire logic [LANES*LANE_W-1:0] DATA_I,
  output var  logic [LANES*LANE_W-1:0] DATA_O,
  output var  logic                    DATA_OE_O,
  input  wire logic [LANES-1:0]        BYTE_PARITY_LINES_I,
  output var  logic [LANES-1:0]        BYTE_PARITY_LINES_O,
  output var  logic                    BYTE_PARITY_LINES_OE_O
);

  // ---------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------
  if (ADDR_W < PBSP_MIN_ADDR_W || LANES < 1 || LANE_W < 1) begin : g_chk
    $error("pbsp_top: address or lane parameters out of range");
  end

  localparam int WORD_LANE_W = LANE_W + PBSP_PARITY_W;
  localparam int WORD_W      = LANES * WORD_LANE_W;

  typedef struct packed {
    logic                       zz_meta;
    logic                       asleep;
    logic [ADDR_W-1:0]          base;
    logic [PBSP_BURST_W-1:0]    cnt;
    logic                       burst_wr;
    logic                       burst_act;
    logic                       s1_valid;
    logic                       s1_write;
    logic [ADDR_W-1:0]          s1_addr;
    logic [LANES-1:0]           s1_lanes;
    logic                       s2_valid;
    logic [ADDR_W-1:0]          s2_addr;
    logic [LANES-1:0]           s2_lanes;
    logic                       drive;
  } pbsp_state_s;

  pbsp_state_s             st_q;
  pbsp_state_s             st_d;
  pbsp_cmd_s               cmd;
  logic [PBSP_BURST_W-1:0] cnt_next;
  logic                    mem_rd_en;
  logic                    mem_wr_en;
  logic [WORD_W-1:0]       mem_wr_data;
  logic [WORD_W-1:0]       mem_rd_data;

  // ---------------------------------------------------------------------
  // Burst address generation
  // ---------------------------------------------------------------------
  function automatic logic [PBSP_BURST_W-1:0] burst_low(
    input logic [PBSP_BURST_W-1:0] start,
    input logic [PBSP_BURST_W-1:0] step,
    input pbsp_order_e             order
  );
    logic [PBSP_BURST_W-1:0] res;
    res = start;
    case (order)
      PBSP_LINEAR:      res = start + step;
      PBSP_INTERLEAVED: res = start ^ step;
      default:          res = start;
    endcase
    return res;
  endfunction

  // ---------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------
  always_comb begin
    cmd.qual  = ~CLOCK_QUALIFIER_N_I;
    cmd.sel   = ~CHIP_SELECT_FIRST_N_I & CHIP_SELECT_SECOND_I &
                ~CHIP_SELECT_THIRD_N_I;
    cmd.adv   = ADVANCE_OR_LOAD_I;
    cmd.write = ~WRITE_STROBE_N_I;
  end

  assign cnt_next = st_q.cnt + PBSP_BURST_STEP;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Sleep request is asynchronous, so it is resynchronised first
    st_d.zz_meta = SLEEP_REQUEST_I;
    st_d.asleep  = st_q.zz_meta;
    if (st_q.asleep) begin
      // Pending work is dropped; the array itself is untouched
      st_d.s1_valid  = 1'b0;
      st_d.s2_valid  = 1'b0;
      st_d.burst_act = 1'b0;
      st_d.drive     = PBSP_RST_DRIVE;
    end else if (cmd.qual) begin
      // Stage two: write data phase follows the floating edge
      st_d.s2_valid = st_q.s1_valid & st_q.s1_write;
      st_d.s2_addr  = st_q.s1_addr;
      st_d.s2_lanes = st_q.s1_lanes;
      // Drivers only for a selected read; writes and deselects float
      st_d.drive    = st_q.s1_valid & ~st_q.s1_write;
      if (cmd.adv) begin
        st_d.cnt      = cnt_next;
        st_d.s1_valid = st_q.burst_act;
        st_d.s1_write = st_q.burst_wr;
        st_d.s1_addr  = {st_q.base[ADDR_W-1:PBSP_BURST_W],
                         burst_low(st_q.base[PBSP_BURST_W-1:0], cnt_next,
                                   pbsp_order_e'(BURST_ORDER_I))};
        st_d.s1_lanes = ~BYTE_LANE_WRITE_SELECT_N_I;
      end else begin
        st_d.base      = ADDR_I;
        st_d.cnt       = PBSP_BURST_START;
        st_d.burst_act = cmd.sel;
        st_d.burst_wr  = cmd.write;
        st_d.s1_valid  = cmd.sel;
        st_d.s1_write  = cmd.write;
        st_d.s1_addr   = ADDR_I;
        st_d.s1_lanes  = ~BYTE_LANE_WRITE_SELECT_N_I;
      end
    end
  end

  // Power-up state is deselected with the drivers off
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------
  // Array access
  // ---------------------------------------------------------------------
  assign mem_rd_en = cmd.qual & ~st_q.asleep & st_q.s1_valid &
                     ~st_q.s1_write;
  assign mem_wr_en = cmd.qual & ~st_q.asleep & st_q.s2_valid;

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      mem_wr_data[l*WORD_LANE_W +: WORD_LANE_W] =
        {BYTE_PARITY_LINES_I[l], DATA_I[l*LANE_W +: LANE_W]};
    end
  end

  pbsp_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (WORD_LANE_W)
  ) u_mem (
    .clk_i     (CLK_SYS_I),
    .rd_en_i   (mem_rd_en),
    .rd_addr_i (st_q.s1_addr),
    .rd_data_o (mem_rd_data),
    .wr_en_i   (mem_wr_en),
    .wr_addr_i (st_q.s2_addr),
    .wr_lane_i (st_q.s2_lanes),
    .wr_data_i (mem_wr_data)
  );

  // ---------------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------------
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      DATA_O[l*LANE_W +: LANE_W] = mem_rd_data[l*WORD_LANE_W +: LANE_W];
      BYTE_PARITY_LINES_O[l]     = mem_rd_data[l*WORD_LANE_W + LANE_W];
    end
  end

  // Output enable pin is asynchronous, so it gates the registered drive
  assign DATA_OE_O = st_q.drive & ~OUTPUT_DRIVE_ENABLE_N_I &
                     ~st_q.asleep;
  assign BYTE_PARITY_LINES_OE_O = DATA_OE_O;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);

  property p_stall_hold;
    CLOCK_QUALIFIER_N_I && !st_q.asleep |=>
      $stable(st_q.base) && $stable(st_q.cnt) && $stable(st_q.s1_addr) &&
      $stable(st_q.drive) && $stable(mem_rd_data);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("state changed on an ignored edge");

  property p_read_load;
    cmd.qual && cmd.sel && !cmd.adv && !cmd.write && !st_q.asleep |=>
      st_q.s1_valid && !st_q.s1_write && st_q.s1_addr == $past(ADDR_I);
  endproperty
  a_read_load: assert property (p_read_load)
    else $error("read command did not latch its address");

  property p_read_drive;
    cmd.qual && cmd.sel && !cmd.adv && !cmd.write && !st_q.asleep
      ##1 cmd.qual && !st_q.asleep |=> st_q.drive;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data not driven one edge after the command");

  property p_oe_gate;
    OUTPUT_DRIVE_ENABLE_N_I |-> !DATA_OE_O && !BYTE_PARITY_LINES_OE_O;
  endproperty
  a_oe_gate: assert property (p_oe_gate)
    else $error("drivers on while output enable is high");

  property p_back_to_back;
    cmd.qual && cmd.sel && !cmd.adv && !cmd.write && !st_q.asleep
      ##1 cmd.qual && cmd.sel && !cmd.adv && !st_q.asleep |=>
      st_q.s1_valid && st_q.s1_addr == $past(ADDR_I);
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("command after a read was not accepted");

  property p_deselect;
    cmd.qual && !cmd.sel && !cmd.adv ##1 cmd.qual |=> !DATA_OE_O;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("outputs still driven after deselect");

  property p_linear;
    cmd.qual && cmd.adv && !BURST_ORDER_I && !st_q.asleep |=>
      st_q.s1_addr[1:0] == $past(st_q.base[1:0] + st_q.cnt + 2'h1);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear burst address wrong");

  property p_interleave;
    cmd.qual && cmd.adv && BURST_ORDER_I && !st_q.asleep |=>
      st_q.s1_addr[1:0] == $past(st_q.base[1:0] ^ (st_q.cnt + 2'h1));
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved burst address wrong");

  property p_burst_high;
    cmd.qual && cmd.adv && !st_q.asleep |=>
      st_q.s1_addr[ADDR_W-1:2] == $past(st_q.base[ADDR_W-1:2]) &&
      st_q.s1_write == $past(st_q.burst_wr);
  endproperty
  a_burst_high: assert property (p_burst_high)
    else $error("burst changed upper address or direction");

  property p_write_float;
    cmd.qual && cmd.sel && !cmd.adv && cmd.write && !st_q.asleep
      ##1 cmd.qual |=> !DATA_OE_O ##0 !BYTE_PARITY_LINES_OE_O;
  endproperty
  a_write_float: assert property (p_write_float)
    else $error("lines driven in the data phase of a write");

  property p_write_commit;
    cmd.qual && cmd.sel && !cmd.adv && cmd.write && !st_q.asleep
      ##1 cmd.qual && !st_q.asleep ##1 cmd.qual && !st_q.asleep |->
      mem_wr_en && st_q.s2_addr == $past(ADDR_I, 2);
  endproperty
  a_write_commit: assert property (p_write_commit)
    else $error("write data not stored two edges after command");

  property p_sleep_entry;
    SLEEP_REQUEST_I [*2] |=> st_q.asleep && !DATA_OE_O;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not entered within two cycles");

  property p_sleep_drop;
    st_q.asleep |-> !mem_wr_en && !mem_rd_en;
  endproperty
  a_sleep_drop: assert property (p_sleep_drop)
    else $error("array accessed while asleep");

  property p_sleep_exit;
    (!SLEEP_REQUEST_I) [*2] |=> !st_q.asleep;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit)
    else $error("sleep not left within two cycles");

  property p_adv_count;
    cmd.qual && cmd.adv && !st_q.asleep |=>
      st_q.cnt == $past(st_q.cnt) + 2'h1;
  endproperty
  a_adv_count: assert property (p_adv_count)
    else $error("burst counter did not step on advance");

  property p_lane_mask;
    cmd.qual && cmd.sel && !cmd.adv && cmd.write && !st_q.asleep
      ##1 cmd.qual && !st_q.asleep ##1 cmd.qual && !st_q.asleep |->
      st_q.s2_lanes == ~$past(BYTE_LANE_WRITE_SELECT_N_I, 2);
  endproperty
  a_lane_mask: assert property (p_lane_mask)
    else $error("write lanes differ from the command selects");

  // Checked on the first edge after release, where reset no longer masks it
  property p_power_float;
    $past(SYS_RST_I) |-> !DATA_OE_O && !BYTE_PARITY_LINES_OE_O;
  endproperty
  a_power_float: assert property (p_power_float)
    else $error("lines driven right after reset");

endmodule

`default_nettype wire
